// *** design/stc_startup_ctrl.sv ***
// Startup rise time, timeout limit and timeout response controller.
// Assumes a decoded command port (one pulse per command) and a power stage
// that ramps while rampActive is high.
`timescale 1ns/1ps
`default_nettype none
module stc_startup_ctrl
  import stc_pkg::*;
#(
  parameter int TICK_CYCLES = STC_TICK_CYCLES
) (
  input  wire logic        clk,           // 200 MHz clock
  input  wire logic        resetn,        // Async reset, active low
  input  wire logic        loopSlave,     // Stacked loop slave strap
  input  wire logic        cmdValid,      // Command pulse
  input  wire logic        cmdWrite,      // 1 write, 0 read
  input  wire logic [7:0]  cmdCode,       // Command code
  input  wire logic [15:0] cmdData,       // Write data
  output logic             cmdHit,        // Code belongs to this block
  output logic             rspValid,      // Answer pulse
  output logic             rspNack,       // Answer is a NACK
  output logic      [15:0] rspData,       // Read data
  input  wire logic        storeAll,      // Store-all-defaults pulse
  input  wire logic        restoreAll,    // Restore-all-defaults pulse
  input  wire logic [15:0] nvRiseIn,      // Stored rise setting
  input  wire logic [7:0]  nvRespIn,      // Stored response setting
  output logic             nvWrite,       // Nonvolatile write pulse
  output logic      [15:0] nvRiseOut,     // Rise setting to store
  output logic      [7:0]  nvRespOut,     // Response setting to store
  input  wire logic        startReq,      // On, turn-on delay elapsed
  input  wire logic        voutAboveUv,   // Vout above UV fault limit
  input  wire logic        clearFaults,   // Clear status pulse
  input  wire logic        alertMask,     // Masks timeout alert
  output logic             rampActive,    // Soft-start ramp running
  output logic             powerOn,       // Output stage enabled
  output logic             statusByteOther,      // Status byte bit
  output logic             outputVoltageWarningFlag, // Status word bit
  output logic             voutStartupTimeoutFlag,   // Status vout bit
  output logic             communicationFaultBit,    // Status byte COMMUNICATION_FAULT_BIT
  output logic             invalidDataFlag,          // COMMUNICATION_FAULT_BIT invalid data
  output logic             invalidCommandFault,      // COMMUNICATION_FAULT_BIT invalid cmd
  output logic             smbAlert       // Alert to host, active high
);
  stc_tick_if tb ();
  stc_state_t state_q, state_d;
  logic [15:0] riseReg_q, limitReg_q;
  logic [7:0]  respReg_q;
  logic [6:0]  riseProg, limitEff, riseEff;
  logic [12:0] deadline, retryMs;
  logic        deadlineOn, timeoutEvent, badRs, ownCmd;
  logic        rspValid_q, rspNack_q;
  logic [15:0] rspData_q;
  logic        sb_q, vw_q, vt_q, cml_q, idat_q, ivc_q, alert_q;
  logic [2:0]  wrRs;

  stc_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk    (clk),
    .resetn (resetn),
    .tb     (tb)
  );

  stc_quantize #(.ZERO_IS_OFF(1'b0)) u_qrise (
    .mant  (riseReg_q[STC_MANT_W-1:0]),
    .effMs (riseProg)
  );

  stc_quantize #(.ZERO_IS_OFF(1'b1)) u_qlimit (
    .mant  (limitReg_q[STC_MANT_W-1:0]),
    .effMs (limitEff)
  );

  assign riseEff = loopSlave ? STC_SLAVE_RISE : riseProg;

  assign ownCmd = (cmdCode == STC_CMD_RISE) || (cmdCode == STC_CMD_LIMIT)
                  || (cmdCode == STC_CMD_RESP);
  assign cmdHit = ownCmd;
  assign wrRs   = cmdData[STC_RS_POS +: 3];
  assign badRs  = (cmdCode == STC_CMD_RESP) && (wrRs != STC_RS_NONE)
                  && (wrRs != STC_RS_RETRY);

  // rise setting, low seven bits only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      riseReg_q <= STC_RISE_RESET;
    end else if (restoreAll) begin
      riseReg_q <= nvRiseIn & STC_MANT_WMASK;
    end else if (cmdValid && cmdWrite && !loopSlave
                 && cmdCode == STC_CMD_RISE) begin
      riseReg_q <= cmdData & STC_MANT_WMASK;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      limitReg_q <= STC_LIMIT_RESET;
    end else if (restoreAll) begin
      limitReg_q <= STC_LIMIT_RESET;
    end else if (cmdValid && cmdWrite && !loopSlave
                 && cmdCode == STC_CMD_LIMIT) begin
      limitReg_q <= cmdData & STC_MANT_WMASK;
    end
  end

  // response setting; wait field mirrors restart top bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      respReg_q <= STC_RESP_RESET;
    end else if (restoreAll) begin
      respReg_q <= (nvRespIn & STC_RESP_WMASK)
                   | {5'h00, {3{nvRespIn[STC_RS_TOP_POS]}}};
    end else if (cmdValid && cmdWrite && !loopSlave && !badRs
                 && cmdCode == STC_CMD_RESP) begin
      respReg_q <= (cmdData[7:0] & STC_RESP_WMASK)
                   | {5'h00, {3{cmdData[STC_RS_TOP_POS]}}};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nvWrite   <= 1'b0;
      nvRiseOut <= STC_RISE_RESET;
      nvRespOut <= STC_RESP_RESET;
    end else begin
      nvWrite <= storeAll;
      if (storeAll) begin
        nvRiseOut <= riseReg_q;
        nvRespOut <= respReg_q;
      end
    end
  end

  // slave NACKs; bad restart data NACKs too
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rspValid_q <= 1'b0;
      rspNack_q  <= 1'b0;
      rspData_q  <= '0;
    end else begin
      rspValid_q <= cmdValid && ownCmd;
      rspNack_q  <= cmdValid && ownCmd && (loopSlave || (cmdWrite && badRs));
      if (cmdValid && ownCmd && !cmdWrite && !loopSlave) begin
        unique case (cmdCode)
          STC_CMD_RISE:  rspData_q <= riseReg_q;
          STC_CMD_LIMIT: rspData_q <= limitReg_q;
          default:       rspData_q <= {8'h00, respReg_q};
        endcase
      end
    end
  end
  assign rspValid = rspValid_q;
  assign rspNack  = rspNack_q;
  assign rspData  = rspData_q;

  // deadline: none, the limit, or rise plus four seconds
  assign deadlineOn = (limitEff != '0);
  assign deadline   = (limitEff < riseEff) ? (13'(riseEff) + STC_LATE_MS)
                                           : 13'(limitEff);
  assign retryMs    = 13'(riseEff) * 13'(STC_RETRY_MULT);
  assign timeoutEvent = (state_q == STC_RAMP) && deadlineOn && !voutAboveUv
                        && (tb.msCount >= deadline);

  always_comb begin
    state_d  = state_q;
    tb.clear = 1'b0;
    unique case (state_q)
      STC_IDLE: begin
        if (startReq) begin
          state_d  = STC_RAMP;
          tb.clear = 1'b1;
        end
      end
      STC_RAMP: begin
        // ignore keeps running, else shutdown and retry or latch
        if (timeoutEvent) begin
          if (!respReg_q[STC_IGNORE_POS]) begin
            state_d = STC_ON;
          end else if (respReg_q[STC_RS_POS +: 3] == STC_RS_RETRY) begin
            state_d  = STC_RETRY;
            tb.clear = 1'b1;
          end else begin
            state_d = STC_LATCH;
          end
        end else if (voutAboveUv && tb.msCount >= 13'(riseEff)) begin
          state_d = STC_ON;
        end
      end
      STC_ON: begin
      end
      STC_RETRY: begin
        if (tb.msCount >= retryMs) begin
          state_d  = STC_RAMP;
          tb.clear = 1'b1;
        end
      end
      STC_LATCH: begin
        if (clearFaults) begin
          state_d = STC_IDLE;
        end
      end
    endcase
    if (!startReq) begin
      state_d = STC_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= STC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end
  assign rampActive = (state_q == STC_RAMP);
  assign powerOn    = (state_q == STC_RAMP) || (state_q == STC_ON);

  // timeout status flags, set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sb_q <= 1'b0;
      vw_q <= 1'b0;
      vt_q <= 1'b0;
    end else begin
      sb_q <= timeoutEvent || (sb_q && !clearFaults);
      vw_q <= timeoutEvent || (vw_q && !clearFaults);
      vt_q <= timeoutEvent || (vt_q && !clearFaults);
    end
  end

  // communication flags, set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cml_q  <= 1'b0;
      idat_q <= 1'b0;
      ivc_q  <= 1'b0;
    end else begin
      ivc_q  <= (cmdValid && ownCmd && loopSlave) || (ivc_q && !clearFaults);
      idat_q <= (cmdValid && cmdWrite && badRs && !loopSlave)
                || (idat_q && !clearFaults);
      cml_q  <= (cmdValid && ownCmd && (loopSlave || (cmdWrite && badRs)))
                || (cml_q && !clearFaults);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= (vt_q && !alertMask) || cml_q;
    end
  end

  assign statusByteOther          = sb_q;
  assign outputVoltageWarningFlag = vw_q;
  assign voutStartupTimeoutFlag   = vt_q;
  assign communicationFaultBit    = cml_q;
  assign invalidDataFlag          = idat_q;
  assign invalidCommandFault      = ivc_q;
  assign smbAlert                 = alert_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_rise_fixed_bits: assert property (riseReg_q[15:7] == '0)
    else $error("rise setting upper bits not zero");
  a_slave_rise_lock: assert property (loopSlave |-> riseEff == STC_SLAVE_RISE)
    else $error("slave rise time not 100 ms");
  a_slave_nack_ivc: assert property (cmdValid && ownCmd && loopSlave
    |=> rspValid && rspNack && invalidCommandFault ##1 smbAlert)
    else $error("slave access not refused");
  a_no_limit_off: assert property (limitReg_q == '0 |-> !timeoutEvent)
    else $error("timeout with limit disabled");
  a_ramp_not_early: assert property (timeoutEvent
    |-> tb.msCount >= 13'(limitEff))
    else $error("timeout before limit elapsed");
  a_timeout_flags: assert property (timeoutEvent
    |=> statusByteOther && outputVoltageWarningFlag && voutStartupTimeoutFlag)
    else $error("timeout flags not set");
  a_ignore_runs: assert property (timeoutEvent && startReq
    && !respReg_q[STC_IGNORE_POS] |=> state_q == STC_ON && powerOn)
    else $error("ignore mode shut down");
  a_latch_off: assert property (timeoutEvent && startReq
    && respReg_q[STC_IGNORE_POS] && respReg_q[STC_RS_POS +: 3] == STC_RS_NONE
    |=> state_q == STC_LATCH && !powerOn)
    else $error("latch mode did not shut down");
  a_retry_wait: assert property (state_q == STC_RETRY && startReq
    && tb.msCount >= retryMs |=> rampActive)
    else $error("retry did not restart ramp");
  a_bad_rs_kept: assert property (cmdValid && cmdWrite && badRs
    && !restoreAll |=> $stable(respReg_q) && communicationFaultBit)
    else $error("bad restart field accepted");
  a_restore_limit: assert property (restoreAll |=> limitReg_q == '0)
    else $error("restore left limit set");

  c_timeout_retry: cover property (timeoutEvent ##1 state_q == STC_RETRY);
  c_normal_start: cover property (rampActive ##1 state_q == STC_ON);
  c_slave_access: cover property (cmdValid && ownCmd && loopSlave);
  c_timeout_latch: cover property (timeoutEvent ##1 state_q == STC_LATCH);
endmodule
`default_nettype wire

// *** design/stc_pkg.sv ***
// Constants, command codes and types for the startup rise and timeout block.
// Assumes a 200 MHz clock and a command decoder that hands over one
// already-framed command per valid pulse.
package stc_pkg;
  localparam logic [7:0]  STC_CMD_RISE    = 8'h61;
  localparam logic [7:0]  STC_CMD_LIMIT   = 8'h62;
  localparam logic [7:0]  STC_CMD_RESP    = 8'h63;
  localparam logic [15:0] STC_RISE_RESET  = 16'h0003;
  localparam logic [15:0] STC_LIMIT_RESET = 16'h0000;
  localparam logic [7:0]  STC_RESP_RESET  = 8'hbf;
  localparam logic [15:0] STC_MANT_WMASK  = 16'h007f;
  localparam logic [7:0]  STC_RESP_WMASK  = 8'hb8;
  localparam int          STC_MANT_W      = 7;
  localparam int          STC_MS_W        = 13;
  localparam int          STC_IGNORE_POS  = 7;
  localparam int          STC_RS_POS      = 3;
  localparam int          STC_RS_TOP_POS  = 5;
  localparam int          STC_TD_POS      = 0;
  localparam logic [2:0]  STC_RS_NONE     = 3'h0;
  localparam logic [2:0]  STC_RS_RETRY    = 3'h7;
  localparam logic [6:0]  STC_SLAVE_RISE  = 7'h64;
  localparam int          STC_LATE_S      = 4;
  localparam logic [12:0] STC_LATE_MS     = 13'(STC_LATE_S * 1000);
  localparam logic [3:0]  STC_RETRY_MULT  = 4'h7;
  localparam int          STC_CLK_NS      = 5;
  localparam int          STC_TICK_NS     = 1000000;
  localparam int          STC_TICK_CYCLES = STC_TICK_NS / STC_CLK_NS;
  localparam logic [6:0]  STC_BKT_MAX [14] = '{7'h01, 7'h02, 7'h03, 7'h04,
    7'h05, 7'h06, 7'h09, 7'h0c, 7'h11, 7'h16, 7'h20, 7'h2c, 7'h3e, 7'h56};
  localparam logic [6:0]  STC_BKT_MS [15] = '{7'h01, 7'h02, 7'h03, 7'h04,
    7'h05, 7'h06, 7'h07, 7'h0a, 7'h0e, 7'h13, 7'h1b, 7'h25, 7'h34, 7'h48,
    7'h64};
  typedef enum logic [2:0] {
    STC_IDLE, STC_RAMP, STC_ON, STC_RETRY, STC_LATCH
  } stc_state_t;
endpackage

// *** design/stc_tick_if.sv ***
// Millisecond time base shared between the controller and its timer.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface stc_tick_if;
  logic        clear;
  logic        tick;
  logic [12:0] msCount;
  modport gen  (input clear, output tick, output msCount);
  modport user (output clear, input tick, input msCount);
endinterface
`default_nettype wire

// *** design/stc_ms_timer.sv ***
// Millisecond tick and elapsed-millisecond counter.
// Assumes clear is a one-cycle pulse from the controller.
`timescale 1ns/1ps
`default_nettype none
module stc_ms_timer
  import stc_pkg::*;
#(
  parameter int TICK_CYCLES = STC_TICK_CYCLES
) (
  input  wire logic clk,     // System clock
  input  wire logic resetn,  // Async reset, active low
  stc_tick_if.gen   tb       // Time base
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  logic [CW-1:0] cyc_q;

  assign tb.tick = (cyc_q == CW'(TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cyc_q <= '0;
    end else if (tb.clear || tb.tick) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= cyc_q + 1'b1;
    end
  end

  // Saturating so a stuck ramp never wraps past a deadline
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tb.msCount <= '0;
    end else if (tb.clear) begin
      tb.msCount <= '0;
    end else if (tb.tick && !(&tb.msCount)) begin
      tb.msCount <= tb.msCount + 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** design/stc_quantize.sv ***
// Maps a programmed millisecond mantissa onto the supported time set.
// Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module stc_quantize
  import stc_pkg::*;
#(
  parameter bit ZERO_IS_OFF = 1'b0
) (
  input  wire logic [6:0] mant,   // Programmed mantissa
  output logic      [6:0] effMs   // Effective time, zero means none
);
  // bucket search, zero lands in 1 ms
  always_comb begin
    effMs = STC_BKT_MS[14];
    for (int i = 13; i >= 0; i--) begin
      if (mant <= STC_BKT_MAX[i]) begin
        effMs = STC_BKT_MS[i];
      end
    end
    if (ZERO_IS_OFF && mant == '0) begin
      effMs = '0;
    end
  end
endmodule
`default_nettype wire

// *** testbench/stc_host_model.sv ***
// Host side of the decoded command port: one command at a time.
// Assumes the answer pulse is registered on the taking edge itself.
`timescale 1ns/1ps
`default_nettype none
module stc_host_model (
  input  wire logic        clk,      // System clock
  output logic             cmdValid, // Command pulse
  output logic             cmdWrite, // 1 write, 0 read
  output logic      [7:0]  cmdCode,  // Command code
  output logic      [15:0] cmdData,  // Write data
  input  wire logic        rspValid, // Answer pulse
  input  wire logic        rspNack,  // Answer is a NACK
  input  wire logic [15:0] rspData   // Read data
);
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode  = 8'h00;
    cmdData  = 16'h0000;
  end

  // A missing answer shows as unknown so the caller's compare fails
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [15:0] data, output logic nack,
                      output logic [15:0] rd);
    @(posedge clk);
    #1;
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdCode  = code;
    cmdData  = data;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    cmdWrite = ~wr;
    cmdData  = ~data;
    nack     = (rspValid === 1'b1) ? rspNack : 1'bx;
    rd       = rspData;
  endtask
endmodule
`default_nettype wire

// *** testbench/stc_startup_ctrl_tb.sv ***
// Self-checking bench for the startup rise and timeout controller.
// Assumes a shortened tick of four clocks per millisecond.
`timescale 1ns/1ps
`default_nettype none
module stc_startup_ctrl_tb;
  import stc_pkg::*;
  localparam int TICK = 4;
  logic        clk, resetn, loopSlave, storeAll, restoreAll, startReq;
  logic        voutAboveUv, clearFaults, alertMask, cmdValid, cmdWrite;
  logic        cmdHit, rspValid, rspNack, nvWrite, rampActive, powerOn;
  logic        statusByteOther, outputVoltageWarningFlag, smbAlert;
  logic        voutStartupTimeoutFlag, communicationFaultBit;
  logic        invalidDataFlag, invalidCommandFault;
  logic [7:0]  cmdCode, nvRespIn, nvRespOut;
  logic [15:0] cmdData, rspData, nvRiseIn, nvRiseOut, v;
  int          nFail, samplesChecked, seed, cyc, lim, k;

  stc_startup_ctrl #(.TICK_CYCLES(TICK)) i_stc_startup_ctrl (
    .clk, .resetn, .loopSlave, .cmdValid, .cmdWrite, .cmdCode, .cmdData,
    .cmdHit, .rspValid, .rspNack, .rspData, .storeAll, .restoreAll,
    .nvRiseIn, .nvRespIn, .nvWrite, .nvRiseOut, .nvRespOut, .startReq,
    .voutAboveUv, .clearFaults, .alertMask, .rampActive, .powerOn,
    .statusByteOther, .outputVoltageWarningFlag, .voutStartupTimeoutFlag,
    .communicationFaultBit, .invalidDataFlag, .invalidCommandFault,
    .smbAlert);

  stc_host_model i_stc_host_model (
    .clk, .cmdValid, .cmdWrite, .cmdCode, .cmdData, .rspValid, .rspNack,
    .rspData);

  always #2.5 clk = ~clk;

  function automatic int quant(input int m);
    int lo [14] = '{1, 2, 3, 4, 5, 6, 9, 12, 17, 22, 32, 44, 62, 86};
    int ms [15] = '{1, 2, 3, 4, 5, 6, 7, 10, 14, 19, 27, 37, 52, 72, 100};
    int i;
    i = 0;
    while (i < 14 && m > lo[i]) i++;
    return ms[i];
  endfunction

  task automatic finish_test();
    if (nFail == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [7:0] code,
                     input logic [15:0] d, input logic nk,
                     input logic [15:0] exp);
    logic        n;
    logic [15:0] r;
    i_stc_host_model.xfer(wr, code, d, n, r);
    chk({15'h0000, n}, {15'h0000, nk});
    if (!wr && !nk) chk(r, exp);
  endtask

  task automatic pulse(ref logic s);
    @(posedge clk);
    #1;
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
  endtask

  task automatic waitv(ref logic s, input logic lvl, output int c);
    c = 0;
    while (s !== lvl && c < 20000) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask

  // Tick phase and pipeline stages give a few clocks of slack
  task automatic chkms(input int c, input int ms);
    chk(16'(c >= ms * TICK - 2 && c <= ms * TICK + 8), 16'h0001);
  endtask

  task automatic run(input int ms);
    @(posedge clk);
    #1;
    startReq = 1'b1;
    waitv(voutStartupTimeoutFlag, 1'b1, cyc);
    chkms(cyc, ms);
  endtask

  task automatic stop();
    @(posedge clk);
    #1;
    startReq = 1'b0;
    voutAboveUv = 1'b0;
    pulse(clearFaults);
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    nFail++;
    finish_test();
  end

  initial begin
    seed = 32'hd02a;
    {clk, resetn, loopSlave, storeAll, restoreAll, startReq} = 6'h00;
    {voutAboveUv, clearFaults, alertMask} = 3'h0;
    nvRiseIn = 16'h0001;
    nvRespIn = 8'hbf;
    repeat (5) @(posedge clk);
    #1;
    resetn = 1'b1;
    acc(1'b0, STC_CMD_RISE, 16'h0000, 1'b0, 16'h0003);
    chk({15'h0000, cmdHit}, 16'h0001);
    acc(1'b0, STC_CMD_LIMIT, 16'h0000, 1'b0, 16'h0000);
    acc(1'b0, STC_CMD_RESP, 16'h0000, 1'b0, 16'h00bf);
    acc(1'b1, STC_CMD_RISE, 16'hffff, 1'b0, 16'h0000);
    acc(1'b0, STC_CMD_RISE, 16'h0000, 1'b0, 16'h007f);
    for (k = 0; k < 8; k++) begin
      v = 16'($random(seed));
      acc(1'b1, STC_CMD_LIMIT, v, 1'b0, 16'h0000);
      acc(1'b0, STC_CMD_LIMIT, 16'h0000, 1'b0, v & 16'h007f);
    end
    acc(1'b1, STC_CMD_RESP, 16'h0028, 1'b1, 16'h0000);
    @(posedge clk);
    #1;
    chk({13'h0, communicationFaultBit, invalidDataFlag, smbAlert}, 16'h7);
    acc(1'b0, STC_CMD_RESP, 16'h0000, 1'b0, 16'h00bf);
    pulse(clearFaults);
    acc(1'b1, STC_CMD_RISE, 16'h0001, 1'b0, 16'h0000);
    acc(1'b1, STC_CMD_LIMIT, 16'h000a, 1'b0, 16'h0000);
    run(10);
    @(posedge clk);
    #1;
    chk({12'h0, statusByteOther, outputVoltageWarningFlag,
         voutStartupTimeoutFlag, smbAlert}, 16'h000f);
    chk({15'h0, powerOn}, 16'h0000);
    waitv(rampActive, 1'b1, cyc);
    chkms(cyc, 7);
    stop();
    for (k = 0; k < 3; k++) begin
      lim = 1 + (($random(seed) & 32'h7fffffff) % 100);
      acc(1'b1, STC_CMD_LIMIT, 16'(lim), 1'b0, 16'h0000);
      run(quant(lim));
      stop();
    end
    acc(1'b1, STC_CMD_RISE, 16'h0003, 1'b0, 16'h0000);
    acc(1'b1, STC_CMD_LIMIT, 16'h0001, 1'b0, 16'h0000);
    run(4003);
    stop();
    acc(1'b1, STC_CMD_RISE, 16'h0000, 1'b0, 16'h0000);
    voutAboveUv = 1'b1;
    startReq = 1'b1;
    waitv(rampActive, 1'b1, cyc);
    waitv(rampActive, 1'b0, cyc);
    chkms(cyc, 1);
    stop();
    acc(1'b1, STC_CMD_RESP, 16'h0000, 1'b0, 16'h0000);
    acc(1'b0, STC_CMD_RESP, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, STC_CMD_LIMIT, 16'h0002, 1'b0, 16'h0000);
    alertMask = 1'b1;
    run(2);
    repeat (2) @(posedge clk);
    #1;
    chk({14'h0, powerOn, smbAlert}, 16'h0002);
    alertMask = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0, smbAlert}, 16'h0001);
    stop();
    pulse(storeAll);
    chk({7'h0, nvWrite, nvRespOut}, 16'h0100);
    chk(nvRiseOut, 16'h0000);
    pulse(restoreAll);
    acc(1'b0, STC_CMD_LIMIT, 16'h0000, 1'b0, 16'h0000);
    acc(1'b0, STC_CMD_RISE, 16'h0000, 1'b0, 16'h0001);
    acc(1'b0, STC_CMD_RESP, 16'h0000, 1'b0, 16'h00bf);
    startReq = 1'b1;
    repeat (600) @(posedge clk);
    #1;
    chk({14'h0, voutStartupTimeoutFlag, rampActive}, 16'h0001);
    stop();
    acc(1'b1, STC_CMD_RESP, 16'h0080, 1'b0, 16'h0000);
    acc(1'b0, STC_CMD_RESP, 16'h0000, 1'b0, 16'h0080);
    acc(1'b1, STC_CMD_LIMIT, 16'h0002, 1'b0, 16'h0000);
    run(2);
    repeat (32) @(posedge clk);
    #1;
    chk({14'h0, powerOn, rampActive}, 16'h0000);
    stop();
    loopSlave = 1'b1;
    acc(1'b1, STC_CMD_RISE, 16'h0005, 1'b1, 16'h0000);
    acc(1'b0, STC_CMD_LIMIT, 16'h0000, 1'b1, 16'h0000);
    @(posedge clk);
    #1;
    chk({13'h0, invalidCommandFault, communicationFaultBit, smbAlert},
        16'h0007);
    voutAboveUv = 1'b1;
    startReq = 1'b1;
    waitv(rampActive, 1'b1, cyc);
    waitv(rampActive, 1'b0, cyc);
    chkms(cyc, 100);
    stop();
    loopSlave = 1'b0;
    acc(1'b0, STC_CMD_RISE, 16'h0000, 1'b0, 16'h0001);
    finish_test();
  end
endmodule
`default_nettype wire
